/* File: rtl/ptev_pkg.sv */
// Purpose: shared constants for the pin task and event unit
// Assumes: eight channels, 32 pins, one clock
// Notes:   configuration fields travel as packed ports, one slice per channel
package ptev_pkg;
  localparam int          NUM_CH    = 8;
  localparam int          NUM_PINS  = 32;
  localparam int          PSEL_W    = 5;
  localparam logic [1:0]  MODE_DIS  = 2'h0;
  localparam logic [1:0]  MODE_EVT  = 2'h1;
  localparam logic [1:0]  MODE_TASK = 2'h3;
  localparam logic [1:0]  POL_NONE  = 2'h0;
  localparam logic [1:0]  POL_LOTOHI = 2'h1;
  localparam logic [1:0]  POL_HITOLO = 2'h2;
  localparam logic [1:0]  POL_TOGGLE = 2'h3;
  localparam int          SYNC_DEPTH = 2;
  typedef enum logic [1:0] {
    ptev_act_none,
    ptev_act_high,
    ptev_act_low,
    ptev_act_flip
  } ptev_act_t;
endpackage

/* File: rtl/ptev_sync.sv */
// Purpose: two-stage synchroniser for the pin inputs
// Assumes: one clock, synchronous active-high reset
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module ptev_sync #(
  parameter int WIDTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // ptev_sync

/* File: rtl/ptev_unit.sv */
// Purpose: eight-channel pin task and event unit overriding the ordinary port
// Assumes: pin inputs may be asynchronous to core_clk; tasks are one-cycle pulses
// Notes:   two channels on one pin give undefined results
`timescale 1ns/10ps
// Notes on behaviour
// - eight independent channels, each with tasks, an input event and configuration.
// - each channel binds to one pin chosen by its pin-select field.
// - set, clear and a configurable output task per channel.
// - input event on rising, falling or any change of the selected pin.
// - set task drives the selected pin high.
// - clear task drives the selected pin low.
// - output task sets, clears or toggles per the polarity field.
// - one configuration group governs all tasks and the event of a channel.
// - a task-owned pin takes its output only from the channel; an event-owned pin is not driven.
// - ordinary port writes to an owned pin have no effect.
// - disabled channel returns the pin to the ordinary port at once.
// - output task wins over clear, clear over set.
// - events go to and tasks come from the interconnect too.
// - event mode forces input, task mode forces output, disabled follows port.
// - entering task mode loads the level from the initial output field.
// - polarity none output task wins and leaves the pin unchanged.
module ptev_unit (
  input  wire logic                                       core_clk,
  input  wire logic                                       rst,
  input  wire logic [ptev_pkg::NUM_CH-1:0]                sw_task_set,
  input  wire logic [ptev_pkg::NUM_CH-1:0]                sw_task_clear,
  input  wire logic [ptev_pkg::NUM_CH-1:0]                sw_task_out,
  input  wire logic [ptev_pkg::NUM_CH-1:0]                ic_task_set,
  input  wire logic [ptev_pkg::NUM_CH-1:0]                ic_task_clear,
  input  wire logic [ptev_pkg::NUM_CH-1:0]                ic_task_out,
  input  wire logic [ptev_pkg::NUM_CH*2-1:0]              cfg_mode,
  input  wire logic [ptev_pkg::NUM_CH*ptev_pkg::PSEL_W-1:0] cfg_psel,
  input  wire logic [ptev_pkg::NUM_CH*2-1:0]              cfg_polarity,
  input  wire logic [ptev_pkg::NUM_CH-1:0]                initial_output_field,
  input  wire logic [ptev_pkg::NUM_PINS-1:0]              port_out,
  input  wire logic [ptev_pkg::NUM_PINS-1:0]              port_dir,
  input  wire logic [ptev_pkg::NUM_PINS-1:0]              pin_in,
  output logic      [ptev_pkg::NUM_PINS-1:0]              pin_out,
  output logic      [ptev_pkg::NUM_PINS-1:0]              pin_oe,
  output logic      [ptev_pkg::NUM_CH-1:0]                event_in,
  output logic      [ptev_pkg::NUM_CH-1:0]                ch_level
);

  localparam int NC = ptev_pkg::NUM_CH;
  localparam int NP = ptev_pkg::NUM_PINS;
  localparam int PW = ptev_pkg::PSEL_W;

  // one-hot decode of a pin select, used for both ownership and readback
  function automatic logic [NP-1:0] ptev_onehot(input logic [PW-1:0] sel);
    logic [NP-1:0] v;

    v      = '0;
    v[sel] = 1'b1;
    return v;
  endfunction

  // mode decodes, shared by the channel slices and the mode history
  function automatic logic ptev_is_task(input logic [1:0] mode);
    return (mode == ptev_pkg::MODE_TASK);
  endfunction

  function automatic logic ptev_is_evt(input logic [1:0] mode);
    return (mode == ptev_pkg::MODE_EVT);
  endfunction

  // what an output task does for a given polarity; none leaves the pin alone
  function automatic ptev_pkg::ptev_act_t ptev_out_action(input logic [1:0] pol);
    ptev_pkg::ptev_act_t a;

    a = ptev_pkg::ptev_act_none;
    case (pol)
      ptev_pkg::POL_LOTOHI: begin
        a = ptev_pkg::ptev_act_high;
      end

      ptev_pkg::POL_HITOLO: begin
        a = ptev_pkg::ptev_act_low;
      end

      ptev_pkg::POL_TOGGLE: begin
        a = ptev_pkg::ptev_act_flip;
      end

      default: begin
        a = ptev_pkg::ptev_act_none;
      end
    endcase
    return a;
  endfunction

  // synchronised pins and registered per-channel state
  logic [NP-1:0] pin_sync;
  logic [NC-1:0] prev_level;
  logic [NC-1:0] out_level;
  logic [NC-1:0] was_task;

  // next values, one bit per channel
  logic [NC-1:0] next_out_level;
  logic [NC-1:0] next_event;
  logic [NC-1:0] next_was_task;
  logic [NC-1:0] cur_level;

  // per-channel pin masks
  logic [NP-1:0] own_task [NC];
  logic [NP-1:0] own_evt  [NC];
  logic [NP-1:0] drv_val  [NC];

  // masks merged over all channels
  logic [NP-1:0] task_mask;
  logic [NP-1:0] evt_mask;
  logic [NP-1:0] task_val;

  // pins pass two flip-flops before any channel looks at them
  ptev_sync #(
    .WIDTH (NP)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  genvar g;

  // one slice per channel: decode, task arbitration, level and event
  generate
    for (g = 0; g < NC; g++) begin : g_ch
      // configuration fields of this channel
      wire logic [1:0]    mode    = cfg_mode[g*2 +: 2];
      wire logic [1:0]    pol     = cfg_polarity[g*2 +: 2];
      wire logic [PW-1:0] psel    = cfg_psel[g*PW +: PW];
      wire logic          is_task = ptev_is_task(mode);
      wire logic          is_evt  = ptev_is_evt(mode);

      // software and interconnect tasks act alike
      wire logic          t_set   = sw_task_set[g] | ic_task_set[g];
      wire logic          t_clr   = sw_task_clear[g] | ic_task_clear[g];
      wire logic          t_out   = sw_task_out[g] | ic_task_out[g];

      // the selected pin's synchronised level
      wire logic [NP-1:0] sel_hot = ptev_onehot(psel);
      wire logic          lvl     = |(pin_sync & sel_hot);

      // first cycle in task mode; events wait one cycle after task mode
      wire logic          first_task = is_task && !was_task[g];
      wire logic          evt_armed  = is_evt && !was_task[g];

      // edge seen between the last two synchronised samples
      wire logic          rise    = lvl & ~prev_level[g];
      wire logic          fall    = ~lvl & prev_level[g];
      wire logic          change  = lvl ^ prev_level[g];

      ptev_pkg::ptev_act_t act;

      // output first, then clear, then set
      always_comb begin
        act = ptev_pkg::ptev_act_none;
        if (t_out) begin
          act = ptev_out_action(pol);
        end else if (t_clr) begin
          act = ptev_pkg::ptev_act_low;
        end else if (t_set) begin
          act = ptev_pkg::ptev_act_high;
        end else begin
          act = ptev_pkg::ptev_act_none;
        end
      end

      // the first task-mode cycle loads the initial level and ignores tasks
      always_comb begin
        next_out_level[g] = out_level[g];
        if (first_task) begin
          next_out_level[g] = initial_output_field[g];
        end else if (is_task) begin
          case (act)
            ptev_pkg::ptev_act_high: begin
              next_out_level[g] = 1'b1;
            end

            ptev_pkg::ptev_act_low: begin
              next_out_level[g] = 1'b0;
            end

            ptev_pkg::ptev_act_flip: begin
              next_out_level[g] = ~out_level[g];
            end

            default: begin
              next_out_level[g] = out_level[g];
            end
          endcase
        end
      end

      // events only in event mode, never right after leaving task mode
      always_comb begin
        next_event[g] = 1'b0;
        if (evt_armed) begin
          case (pol)
            ptev_pkg::POL_LOTOHI: begin
              next_event[g] = rise;
            end

            ptev_pkg::POL_HITOLO: begin
              next_event[g] = fall;
            end

            ptev_pkg::POL_TOGGLE: begin
              next_event[g] = change;
            end

            default: begin
              next_event[g] = 1'b0;
            end
          endcase
        end
      end

      assign cur_level[g] = lvl;

      // ownership masks and the level driven onto an owned pin
      assign own_task[g] = is_task ? sel_hot : '0;
      assign own_evt[g]  = is_evt ? sel_hot : '0;
      assign drv_val[g]  = (is_task && out_level[g]) ? sel_hot : '0;

      // mode history for the next cycle
      assign next_was_task[g] = is_task;
    end
  endgenerate

  // two channels on one pin simply OR together; software must avoid it
  always_comb begin
    task_mask = '0;
    for (int i = 0; i < NC; i++) begin
      task_mask = task_mask | own_task[i];
    end
  end

  always_comb begin
    evt_mask = '0;
    for (int i = 0; i < NC; i++) begin
      evt_mask = evt_mask | own_evt[i];
    end
  end

  always_comb begin
    task_val = '0;
    for (int i = 0; i < NC; i++) begin
      task_val = task_val | drv_val[i];
    end
  end

  genvar p;

  // task-owned pins ignore port_out, event-owned pins are never driven; a released pin falls back to the port at once
  generate
    for (p = 0; p < NP; p++) begin : g_pin
      wire logic by_task  = task_mask[p];
      wire logic by_event = evt_mask[p];

      assign pin_out[p] = by_task ? task_val[p] : port_out[p];
      assign pin_oe[p]  = by_task | (~by_event & port_dir[p]);
    end
  endgenerate

  // channel output levels
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_level <= '0;
    end else begin
      out_level <= next_out_level;
    end
  end

  // mode history: marks the first cycle of task mode and the first cycle after leaving it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      was_task <= '0;
    end else begin
      was_task <= next_was_task;
    end
  end

  // synchronised level one cycle back, for edge detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_level <= '0;
    end else begin
      prev_level <= cur_level;
    end
  end

  // registered event pulses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_in <= '0;
    end else begin
      event_in <= next_event;
    end
  end

  assign ch_level = out_level;
endmodule // ptev_unit

/* File: tb/ptev_pin_model.sv */
// Purpose: outside world seen at the unit's pins
// Assumes: an outside driver holds every pin the unit does not drive
// Notes:   no pulls; outside level wins only while pin_oe is low
`timescale 1ns/10ps
module ptev_pin_model (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_level,
  output logic      [31:0] pin_in
);
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // ptev_pin_model

/* File: tb/ptev_unit_checker.sv */
// Purpose: port-level assertions on channel 0 (tasks) and channel 1 (events) of the unit
// Assumes: no other channel shares channel 0's pin
// Notes:   tasks count only after a full cycle in task mode
`timescale 1ns/10ps
module ptev_unit_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  sw_task_set,
  input wire logic [7:0]  sw_task_clear,
  input wire logic [7:0]  sw_task_out,
  input wire logic [7:0]  ic_task_clear,
  input wire logic [7:0]  ic_task_out,
  input wire logic [15:0] cfg_mode,
  input wire logic [39:0] cfg_psel,
  input wire logic [15:0] cfg_polarity,
  input wire logic [7:0]  initial_output_field,
  input wire logic [31:0] port_out,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [7:0]  event_in,
  input wire logic [7:0]  ch_level
);
  wire [4:0] p0  = cfg_psel[4:0];
  wire [4:0] p1  = cfg_psel[9:5];
  wire       tm  = cfg_mode[1:0] == 2'h3;
  wire       clr = sw_task_clear[0] | ic_task_clear[0];
  wire       o0  = sw_task_out[0] | ic_task_out[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_init_load: assert property (tm && !$past(tm) |=> ch_level[0] == $past(initial_output_field[0]))
    else $error("initial level not loaded");
  chk_set_high: assert property (tm && $past(tm) && sw_task_set[0] && !clr && !o0 |=> ch_level[0])
    else $error("set task left level low");
  chk_clear_low: assert property (tm && $past(tm) && clr && !o0 |=> !ch_level[0])
    else $error("clear task left level high");
  chk_out_toggle: assert property (tm && $past(tm) && o0 && cfg_polarity[1:0] == 2'h3 |=>
    ch_level[0] != $past(ch_level[0])) else $error("toggle did not flip level");
  chk_out_none: assert property (tm && $past(tm) && o0 && cfg_polarity[1:0] == 2'h0 |=>
    $stable(ch_level[0])) else $error("idle output task moved level");
  chk_owned_out: assert property (tm |-> pin_oe[p0] && pin_out[p0] == ch_level[0])
    else $error("owned pin not driven by channel");
  chk_evt_input: assert property (cfg_mode[3:2] == 2'h1 |-> !pin_oe[p1])
    else $error("event pin driven");
  chk_dis_follow: assert property (cfg_mode[1:0] == 2'h0 |-> pin_out[p0] == port_out[p0])
    else $error("released pin ignores port value");
  chk_evt_pulse: assert property (event_in[1] |=> !event_in[1])
    else $error("event longer than one cycle");
  cover property (tm && $past(tm) && o0 && clr);
  cover property (cfg_mode[1:0] == 2'h0 && $past(tm));
  cover property (event_in[1]);
endmodule // ptev_unit_checker
bind ptev_unit ptev_unit_checker i_chk (.core_clk(core_clk), .rst(rst), .sw_task_set(sw_task_set),
  .sw_task_clear(sw_task_clear), .sw_task_out(sw_task_out), .ic_task_clear(ic_task_clear),
  .ic_task_out(ic_task_out), .cfg_mode(cfg_mode), .cfg_psel(cfg_psel), .port_out(port_out),
  .cfg_polarity(cfg_polarity), .initial_output_field(initial_output_field), .pin_out(pin_out),
  .pin_oe(pin_oe), .event_in(event_in), .ch_level(ch_level));

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the pin task and event unit
// Assumes: channel 0 tasks on pin 5, channel 1 events on pin 9
// Notes:   inputs change at the falling edge only
`timescale 1ns/10ps
module tb_top;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sw_task_set = 8'h00, sw_task_clear = 8'h00, sw_task_out = 8'h00;
  logic [7:0]  ic_task_set = 8'h00, ic_task_clear = 8'h00, ic_task_out = 8'h00;
  logic [15:0] cfg_mode = 16'h0000, cfg_polarity = 16'h0000;
  logic [39:0] cfg_psel = 40'h00_0000_0125;
  logic [7:0]  initial_output_field = 8'h01;
  logic [31:0] port_out = 32'h0000_0000, port_dir = 32'hFFFF_FFFF, ext_level = 32'h0000_0000;
  logic [31:0] pin_in, pin_out, pin_oe;
  logic [7:0]  event_in, ch_level;
  int          failures = 0, comparisons = 0, cycles = 0;
  always #2.5 core_clk = ~core_clk;
  ptev_unit i_ptev_unit (.core_clk(core_clk), .rst(rst), .sw_task_set(sw_task_set),
    .sw_task_clear(sw_task_clear), .sw_task_out(sw_task_out), .ic_task_set(ic_task_set),
    .ic_task_clear(ic_task_clear), .ic_task_out(ic_task_out), .cfg_mode(cfg_mode),
    .cfg_psel(cfg_psel), .cfg_polarity(cfg_polarity), .initial_output_field(initial_output_field),
    .port_out(port_out), .port_dir(port_dir), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .event_in(event_in), .ch_level(ch_level));
  ptev_pin_model i_ptev_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one task pulse on channel 0, then an idle cycle
  task automatic pulse(input logic [2:0] sco, input logic via_ic);
    if (via_ic) {ic_task_set[0], ic_task_clear[0], ic_task_out[0]} = sco;
    else {sw_task_set[0], sw_task_clear[0], sw_task_out[0]} = sco;
    @(negedge core_clk);
    {sw_task_set[0], sw_task_clear[0], sw_task_out[0]} = 3'h0;
    {ic_task_set[0], ic_task_clear[0], ic_task_out[0]} = 3'h0;
    @(negedge core_clk);
  endtask
  task automatic test_tasks;
    cfg_polarity[1:0] = 2'h3;
    cfg_mode[1:0] = 2'h3;
    repeat (2) @(negedge core_clk);
    check(ch_level[0], 1'b1);
    check({pin_oe[5], pin_out[5]}, 2'h3);
    pulse(3'h2, 1'b0);
    check(pin_out[5], 1'b0);
    port_out[5] = 1'b1;
    @(negedge core_clk);
    check(pin_out[5], 1'b0);
    pulse(3'h4, 1'b0);
    check(pin_out[5], 1'b1);
    pulse(3'h1, 1'b1);
    check(ch_level[0], 1'b0);
    pulse(3'h6, 1'b0);
    check(ch_level[0], 1'b0);
    pulse(3'h7, 1'b0);
    check(ch_level[0], 1'b1);
    cfg_polarity[1:0] = 2'h0;
    pulse(3'h3, 1'b0);
    check(ch_level[0], 1'b1);
    cfg_polarity[1:0] = 2'h2;
    pulse(3'h5, 1'b0);
    check(ch_level[0], 1'b0);
    cfg_polarity[1:0] = 2'h1;
    pulse(3'h3, 1'b1);
    check(ch_level[0], 1'b1);
    port_out[5] = 1'b0;
    port_dir[5] = 1'b0;
    cfg_mode[1:0] = 2'h0;
    @(negedge core_clk);
    check({pin_oe[5], pin_out[5]}, 2'h0);
    $display("test_tasks done");
  endtask
  task automatic edge_count(input logic lvl, input logic [31:0] exp);
    int n;
    n = 0;
    ext_level[9] = lvl;
    repeat (6) begin
      @(negedge core_clk);
      if (event_in[1] === 1'b1) n++;
    end
    check(n, exp);
  endtask
  task automatic test_events;
    cfg_mode[3:2] = 2'h1;
    for (int p = 1; p < 4; p++) begin
      cfg_polarity[3:2] = p[1:0];
      @(negedge core_clk);
      check(pin_oe[9], 1'b0);
      edge_count(1'b1, 32'(p != 2));
      edge_count(1'b0, 32'(p != 1));
    end
    $display("test_events done");
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    test_tasks;
    test_events;
    conclude;
  end
endmodule // tb_top
